// file: include/lcd_timing_pkg.sv
package lcd_timing_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] lcd_timing_control_off          = 12'h0094 << 2;  // Index 0x94
  localparam logic [11:0] charge_pump_display_control_off = 12'h0095 << 2;  // Index 0x95
  localparam logic [7:0]  lcd_timing_control_rst          = 8'h00;
  localparam logic [7:0]  charge_pump_display_control_rst = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int base_freq_sel_lo_pos  = 0;
  localparam int drive_duty_lo_pos     = 2;
  localparam int ref_clock_sel_pos     = 4;
  localparam int boost_freq_sel_lo_pos = 5;
  localparam int boost_enable_pos      = 6;
  localparam int display_enable_pos    = 7;

  // ****************************************
  // Divider exponents (main clock, sub clock)
  // ****************************************
  localparam logic [4:0] base_exp_main_0  = 5'h12;
  localparam logic [4:0] base_exp_sub_0   = 5'h09;
  localparam logic [4:0] boost_exp_main_0 = 5'h0E;
  localparam logic [4:0] boost_exp_main_1 = 5'h0C;
  localparam logic [4:0] boost_exp_sub_0  = 5'h05;
  localparam logic [4:0] boost_exp_sub_1  = 5'h03;

  typedef enum logic [1:0] {
    duty_quarter,
    duty_third,
    duty_half,
    duty_static
  } duty_t;

endpackage : lcd_timing_pkg

// file: rtl/lcd_drive_timing_control.sv
// Operation
// RL1: ref_clock_sel 0 picks main oscillator, 1 picks sub oscillator for both dividers.
// RL2: Main tick comes from primary crystal, sub tick from low-speed crystal.
// RL3: Duty code 00 quarter, 01 third, 10 half, 11 static common drive.
// RL4: Base frame clock divides main by 2^18..2^15 or sub by 2^9..2^6.
// RL5: Boost clock divides main by 2^14,12,11,10 or sub by 2^5,3,2,1.
// RL6: display_enable low blanks segments, high allows display drive.
// RL7: boost_enable low stops charge pump, high runs it at chosen rate.
// RL8: Reset clears all control fields: blanked, no boost, quarter duty, main clock.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module lcd_drive_timing_control (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        main_osc_tick,
  input  wire logic        sub_osc_tick,
  output logic             base_clk,
  output logic             boost_clk,
  output logic             display_on,
  output logic [1:0]       drive_duty,
  output logic             static_drive
);

  // ****************************************
  // Register bus
  // ****************************************
  logic [7:0]  lcd_ctl_reg, lcd_ctl_next;
  logic [7:0]  chp_ctl_reg, chp_ctl_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        pready_reg, pready_next;
  logic        pslverr_reg, pslverr_next;

  // ****************************************
  // Address decode
  // ****************************************

  // Address decode shared by read and write paths
  function automatic logic [1:0] decode(input logic [11:0] a);
    if (a == lcd_timing_pkg::lcd_timing_control_off) begin
      return 2'b01;
    end else if (a == lcd_timing_pkg::charge_pump_display_control_off) begin
      return 2'b10;
    end
    return 2'b00;
  endfunction : decode

  // A decoded address names one of the two registers
  function automatic logic is_mapped(input logic [1:0] hit);
    return hit != 2'b00;
  endfunction : is_mapped

  // Registers are one byte wide, so only the low lane strobe counts
  function automatic logic strobe_ok(input logic [3:0] strb);
    return strb[0];
  endfunction : strobe_ok

  // ****************************************
  // Write and read values
  // ****************************************

  // Byte kept in the timing register; bit 7 holds no field
  function automatic logic [7:0] lcd_write_value(input logic [31:0] d);
    logic [7:0] v;
    v    = d[7:0];
    v[7] = 1'b0;
    return v;
  endfunction : lcd_write_value

  // Byte kept in the pump register; bits 5:0 hold no field
  function automatic logic [7:0] chp_write_value(input logic [31:0] d);
    logic [7:0] v;
    v                                     = 8'h00;
    v[lcd_timing_pkg::display_enable_pos] = d[lcd_timing_pkg::display_enable_pos];
    v[lcd_timing_pkg::boost_enable_pos]   = d[lcd_timing_pkg::boost_enable_pos];
    return v;
  endfunction : chp_write_value

  // Word returned by a read; the timing register is write-only
  function automatic logic [31:0] read_value(input logic [1:0] hit,
                                             input logic [7:0] chp);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (hit[1]) begin
      w = {24'h00_0000, chp};
    end
    return w;
  endfunction : read_value

  // ****************************************
  // Bus state
  // ****************************************

  // Next register values and bus answer, one wait state
  always_comb begin
    logic [1:0] hit;
    logic       acc;
    hit          = decode(paddr);
    acc          = psel && penable && !pready_reg;
    lcd_ctl_next = lcd_ctl_reg;
    chp_ctl_next = chp_ctl_reg;
    prdata_next  = 32'h0000_0000;
    pready_next  = acc;
    pslverr_next = acc && !is_mapped(hit);
    if (acc && pwrite && strobe_ok(pstrb)) begin
      if (hit[0]) begin
        lcd_ctl_next = lcd_write_value(pwdata);  // RL1 RL3 RL4 RL5
      end
      if (hit[1]) begin
        chp_ctl_next = chp_write_value(pwdata);  // RL6 RL7
      end
    end
    if (acc && !pwrite) begin
      prdata_next = read_value(hit, chp_ctl_reg);  // Write-only timing reg reads zero
    end
  end

  // Control and bus answer registers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lcd_ctl_reg <= lcd_timing_pkg::lcd_timing_control_rst;  // RL8
      chp_ctl_reg <= lcd_timing_pkg::charge_pump_display_control_rst;  // RL8
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      lcd_ctl_reg <= lcd_ctl_next;
      chp_ctl_reg <= chp_ctl_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // Bus outputs straight from their registers
  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  // ****************************************
  // Field extraction
  // ****************************************
  // Two-bit field at a given position of a control byte
  function automatic logic [1:0] field_pair(input logic [7:0] r,
                                            input int         pos);
    return r[pos +: 2];
  endfunction : field_pair

  // Single flag at a given position of a control byte
  function automatic logic field_bit(input logic [7:0] r,
                                     input int         pos);
    return r[pos];
  endfunction : field_bit

  logic [1:0] base_sel, boost_sel, duty_sel;
  logic       use_sub, disp_en, boost_en;
  // Control fields split out for the dividers and outputs
  assign base_sel  = field_pair(lcd_ctl_reg, lcd_timing_pkg::base_freq_sel_lo_pos);
  assign duty_sel  = field_pair(lcd_ctl_reg, lcd_timing_pkg::drive_duty_lo_pos);
  assign use_sub   = field_bit(lcd_ctl_reg, lcd_timing_pkg::ref_clock_sel_pos);
  assign boost_sel = field_pair(lcd_ctl_reg, lcd_timing_pkg::boost_freq_sel_lo_pos);
  assign boost_en  = field_bit(chp_ctl_reg, lcd_timing_pkg::boost_enable_pos);
  assign disp_en   = field_bit(chp_ctl_reg, lcd_timing_pkg::display_enable_pos);

  // ****************************************
  // Dividers
  // ****************************************
  logic [17:0] div_cnt_reg, div_cnt_next;
  logic        base_clk_reg, base_clk_next;
  logic        boost_clk_reg, boost_clk_next;
  logic        disp_reg, disp_next;
  logic [1:0]  duty_reg, duty_next;
  logic        static_reg, static_next;
  logic [4:0]  base_exp, boost_exp;

  // ****************************************
  // Divider exponent tables
  // ****************************************

  // Base frame exponent: one period is 2^n reference ticks
  function automatic logic [4:0] base_exponent(input logic       sub,
                                               input logic [1:0] code);
    logic [4:0] top;
    logic [4:0] n;
    top = sub ? lcd_timing_pkg::base_exp_sub_0
              : lcd_timing_pkg::base_exp_main_0;  // RL1
    n   = top;
    unique case (code)  // RL4
      2'b00: n = top;
      2'b01: n = top - 5'h01;
      2'b10: n = top - 5'h02;
      2'b11: n = top - 5'h03;
    endcase
    return n;
  endfunction : base_exponent

  // Boost exponent: code 00 stands apart, 01 to 11 step down by one
  function automatic logic [4:0] boost_exponent(input logic       sub,
                                                input logic [1:0] code);
    logic [4:0] first;
    logic [4:0] step;
    logic [4:0] n;
    first = sub ? lcd_timing_pkg::boost_exp_sub_0
                : lcd_timing_pkg::boost_exp_main_0;  // RL1
    step  = sub ? lcd_timing_pkg::boost_exp_sub_1
                : lcd_timing_pkg::boost_exp_main_1;  // RL1
    n     = first;
    unique case (code)  // RL5
      2'b00: n = first;
      2'b01: n = step;
      2'b10: n = step - 5'h01;
      2'b11: n = step - 5'h02;
    endcase
    return n;
  endfunction : boost_exponent

  // Counter bit n-1 flips every 2^(n-1) ticks; toggling on it gives 2^n
  function automatic logic half_period_edge(input logic [17:0] flipped,
                                            input logic [4:0]  n);
    logic [4:0] idx;
    idx = n - 5'h01;
    return flipped[idx];
  endfunction : half_period_edge

  // A square wave flips on every half-period edge
  function automatic logic next_square(input logic q,
                                       input logic flip);
    return q ^ flip;
  endfunction : next_square

  // Reference tick of the chosen oscillator
  function automatic logic select_tick(input logic sub,
                                       input logic main_t,
                                       input logic sub_t);
    return sub ? sub_t : main_t;
  endfunction : select_tick

  // Static drive leaves the commons unmultiplexed
  function automatic logic duty_is_static(input logic [1:0] code);
    return code == 2'(lcd_timing_pkg::duty_static);
  endfunction : duty_is_static

  // ****************************************
  // Divider chain
  // ****************************************

  // Exponents for the fields now in force
  always_comb begin
    base_exp  = base_exponent(use_sub, base_sel);  // RL1 RL4
    boost_exp = boost_exponent(use_sub, boost_sel);  // RL1 RL5
  end

  // Reference tick selection; a field change may cut one period short
  always_comb begin
    logic        tick;
    logic [17:0] cnt_inc;
    logic [17:0] flipped;
    tick           = select_tick(use_sub, main_osc_tick, sub_osc_tick);  // RL1 RL2
    cnt_inc        = div_cnt_reg + 18'h0_0001;
    div_cnt_next   = tick ? cnt_inc : div_cnt_reg;
    flipped        = tick ? (cnt_inc ^ div_cnt_reg) : 18'h0_0000;
    base_clk_next  = next_square(base_clk_reg, half_period_edge(flipped, base_exp));  // RL4
    boost_clk_next = boost_en ? next_square(boost_clk_reg,
                                            half_period_edge(flipped, boost_exp))
                              : 1'b0;  // RL7
    disp_next      = disp_en;  // RL6
    duty_next      = duty_sel;  // RL3
    static_next    = duty_is_static(duty_sel);  // RL3
  end

  // ****************************************
  // Divider registers
  // ****************************************

  // Counter, square waves and registered panel controls
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt_reg   <= 18'h0_0000;
      base_clk_reg  <= 1'b0;
      boost_clk_reg <= 1'b0;
      disp_reg      <= 1'b0;
      duty_reg      <= 2'h0;
      static_reg    <= 1'b0;
    end else begin
      div_cnt_reg   <= div_cnt_next;
      base_clk_reg  <= base_clk_next;
      boost_clk_reg <= boost_clk_next;
      disp_reg      <= disp_next;
      duty_reg      <= duty_next;
      static_reg    <= static_next;
    end
  end

  // ****************************************
  // Panel outputs
  // ****************************************

  // Panel side outputs straight from their registers
  assign base_clk     = base_clk_reg;
  assign boost_clk    = boost_clk_reg;
  assign display_on   = disp_reg;
  assign drive_duty   = duty_reg;
  assign static_drive = static_reg;

endmodule : lcd_drive_timing_control

// file: dv/lcd_panel_model.sv
`timescale 1ns/1ps
// Oscillator ticks and panel period probe
module lcd_panel_model (
  input  logic clk_sys,
  input  logic base_clk,
  input  logic boost_clk,
  output logic main_osc_tick,
  output logic sub_osc_tick,
  output int   base_per,
  output int   boost_per
);
  logic [1:0] ph = 2'h0;
  logic       bq = 1'b0;
  logic       cq = 1'b0;
  int         bc = 0;
  int         cc = 0;
  assign main_osc_tick = ph[0];
  assign sub_osc_tick  = &ph;
  // Clock cycles between rising edges
  always @(posedge clk_sys) begin
    ph <= ph + 2'h1;
    bq <= base_clk;
    cq <= boost_clk;
    bc <= (base_clk && !bq) ? 1 : bc + 1;
    cc <= (boost_clk && !cq) ? 1 : cc + 1;
    if (base_clk && !bq) base_per <= bc;
    if (boost_clk && !cq) boost_per <= cc;
  end
endmodule : lcd_panel_model

// file: dv/lcd_drive_timing_control_checker.sv
`timescale 1ns/1ps
module lcd_drive_timing_control_checker (
  input logic        clk_sys,
  input logic        arst_n,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        boost_clk,
  input logic        display_on,
  input logic [1:0]  drive_duty,
  input logic        static_drive
);
  // Accepted access decode
  logic acc;
  logic wl;
  logic wc;
  assign acc = psel && penable && !pready;
  assign wl  = acc && pwrite && paddr == lcd_timing_pkg::lcd_timing_control_off;
  assign wc  = acc && pwrite && paddr == lcd_timing_pkg::charge_pump_display_control_off;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  ans_wait_a: assert property (acc |=> pready) else $error("late answer");
  ans_pulse_a: assert property (pready |=> !pready) else $error("long answer");
  idle_data_a: assert property (!pready |-> prdata == 32'h0000_0000) else $error("stray data");
  duty_set_a: assert property (wl |=> ##1 drive_duty == $past(pwdata[3:2], 2))
    else $error("duty not set");
  static_map_a: assert property (static_drive == (drive_duty == 2'h3))
    else $error("static wrong");
  disp_set_a: assert property (wc |=> ##1 display_on == $past(pwdata[7], 2))
    else $error("display not set");
  boost_off_a: assert property (wc && !pwdata[6] |=> ##1 !boost_clk [*4])
    else $error("boost runs");
  rst_clear_a: assert property ($rose(arst_n) |-> !display_on && drive_duty == 2'h0)
    else $error("reset state");
endmodule : lcd_drive_timing_control_checker
bind lcd_drive_timing_control lcd_drive_timing_control_checker u_chk (.*);

// file: dv/lcd_drive_timing_control_test.sv
`timescale 1ns/1ps
module lcd_drive_timing_control_test;
  logic        clk_sys = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [3:0]  pstrb = 4'hF;
  logic        pready, pslverr, main_osc_tick, sub_osc_tick, base_clk, boost_clk, er;
  logic        display_on, static_drive;
  logic [1:0]  drive_duty;
  int          base_per, boost_per, n_fail = 0, checked = 0;
  localparam logic [11:0] lcd_a = lcd_timing_pkg::lcd_timing_control_off;
  localparam logic [11:0] chp_a = lcd_timing_pkg::charge_pump_display_control_off;
  lcd_drive_timing_control u_lcd_drive_timing_control (.clk_sys, .arst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .main_osc_tick,
    .sub_osc_tick, .base_clk, .boost_clk, .display_on, .drive_duty, .static_drive);
  lcd_panel_model u_lcd_panel_model (.clk_sys, .base_clk, .boost_clk, .main_osc_tick,
    .sub_osc_tick, .base_per, .boost_per);
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic chk(input string s, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s exp %h got %h", s, exp, got);
    end
  endtask : chk
  task give_verdict;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  // One APB transfer, then an idle cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys) penable <= 1;
    do begin @(posedge clk_sys); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin n_fail++; give_verdict(); end
    rd = prdata; er = pslverr;
    psel <= 0; penable <= 0;
    @(posedge clk_sys);
  endtask : apb
  task automatic t_regs;
    chk("disp", display_on, 0);
    chk("duty", drive_duty, 0);
    apb(0, chp_a, 0); chk("chp", rd, 0);
    for (int i = 0; i < 4; i++) begin
      apb(1, lcd_a, i << 2); chk("duty", drive_duty, i);
      chk("stat", static_drive, i == 3);
    end
    apb(0, lcd_a, 0); chk("wo", rd, 0);
    apb(1, chp_a, 32'h0000_00C0); chk("disp", display_on, 1);
    apb(0, chp_a, 0); chk("chp", rd, 32'h0000_00C0);
    apb(1, chp_a, 0); chk("disp", display_on, 0);
    chk("boost", boost_clk, 0);
    apb(0, 12'h000, 0); chk("err", er, 1);
  endtask : t_regs
  task automatic meas(input logic [7:0] v, input int eb, input int ec);
    apb(1, lcd_a, {24'h0, v});
    repeat (3 * (eb > ec ? eb : ec) + 20) @(posedge clk_sys);
    if (eb > 0) chk("base", base_per, eb);
    chk("boost", boost_per, ec);
  endtask : meas
  initial begin
    repeat (5) @(posedge clk_sys);
    arst_n <= 1;
    @(posedge clk_sys);
    t_regs;
    apb(1, chp_a, 32'h0000_00C0);
    meas(8'h13, 256, 128);
    meas(8'h72, 512, 8);
    meas(8'h60, 0, 2048);
    give_verdict;
  end
endmodule : lcd_drive_timing_control_test
